// [dv/host_model.sv]
/*
 * host side of the configuration link, reduced to the levels it sets.
 * assumes the bench decides when the motor should be enabled.
 */
`timescale 1ns/10ps
module host_model
   import pwm_ctl_pkg::*;
(
   input wire logic run_req,
   output logic run_bit,
   output logic brake_bit,
   output logic [5:0] dead_time_field,
   output logic [SPEED_W-1:0] low_power_entry_voltage
);
   assign run_bit = run_req;
   assign brake_bit = !run_req;
   assign dead_time_field = 6'h1e;
   assign low_power_entry_voltage = 10'h020;
endmodule

// [dv/tb.sv]
/*
 * self-checking bench for the speed reference and pwm timing block.
 * assumes shortened precharge and low power dwell counts.
 */
`timescale 1ns/10ps
module tb;
   import pwm_ctl_pkg::*;
   // ****************************************************************
   // stimulus and checks
   // ****************************************************************
   logic clk_sys = 1'b0, reset = 1'b1, run_req = 1'b0;
   logic sync_loss_detect = 1'b0, run_bit, brake_bit;
   logic speed_source_select = 1'b0, pwm_period_start;
   logic [9:0] speed_input_pin = 10'h000, serial_speed_reference = 10'h000;
   logic [9:0] max_speed_voltage = 10'h300, min_speed_voltage = 10'h100;
   logic [9:0] excitation_start_voltage = 10'h180, low_power_entry_voltage;
   logic [9:0] max_reference_speed = 10'h050, min_reference_speed = 10'h010;
   logic [3:0] speed_unit = 4'h3;
   logic [7:0] pwm_period_field = 8'h00;
   logic [5:0] dead_time_field;
   logic [1:0] switching_mode_field = 2'h1;
   logic [2:0] precharge_time_field = 3'h1, motor_state, gate_high, gate_low;
   logic [6:0] modulation_index = 7'h00;
   logic [10:0] duty_u = 11'h000, duty_v = 11'h000, duty_w = 11'h000;
   logic [13:0] ref_freq;
   logic sync_loss_flag, fault_clear, low_power_mode, two_phase_active;
   int mismatches = 0, checked = 0, n;
   logic [15:0] e;
   logic tp;

   always #50 clk_sys = !clk_sys;

   host_model u_host (.run_req, .run_bit, .brake_bit, .dead_time_field,
      .low_power_entry_voltage);
   motor_speed_pwm_control #(.PRECHARGE_STEP_CYC(20), .LOW_POWER_DWELL_CYC(30))
      DUT (.clk_sys, .reset, .speed_input_pin, .sync_loss_detect, .run_bit,
      .brake_bit, .speed_source_select, .serial_speed_reference,
      .max_speed_voltage, .min_speed_voltage, .excitation_start_voltage,
      .low_power_entry_voltage, .max_reference_speed, .min_reference_speed,
      .speed_unit, .pwm_period_field, .dead_time_field, .switching_mode_field,
      .precharge_time_field, .modulation_index, .duty_u, .duty_v, .duty_w,
      .gate_high, .gate_low, .ref_freq, .sync_loss_flag, .fault_clear,
      .low_power_mode, .two_phase_active, .pwm_period_start, .motor_state);

   function automatic logic [15:0] lin(input int p);
      int fl, fh;
      fl = min_reference_speed * speed_unit;
      fh = max_reference_speed * speed_unit;
      return 16'(fl + (fh - fl) * (p - 256) / 512);
   endfunction

   task chk(input string nm, input logic [15:0] e, input logic [15:0] s);
      checked++;
      if (s !== e) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask

   task wait_st(input logic [2:0] st, input int lim);
      n = 0;
      while (motor_state !== st && n < lim) begin
         @(negedge clk_sys);
         n++;
      end
      chk("state", 16'(st), 16'(motor_state));
   endtask

   task periods(input int k);
      repeat (k) begin
         n = 0;
         do begin
            @(negedge clk_sys);
            n++;
         end while (pwm_period_start !== 1'b1 && n < 2000);
      end
   endtask

   task test_done;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   initial begin
      #4000000;
      mismatches++;
      test_done();
   end

   initial begin
      void'($urandom(11258));
      repeat (16) @(negedge clk_sys);
      reset = 1'b0;
      @(negedge clk_sys);
      chk("gates", 16'h0000, 16'({gate_high, gate_low}));
      wait_st(3'h2, 600);
      $display("reset test done");
      for (int i = 0; i < 3; i++) begin
         pwm_period_field = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom);
         periods(3);
         e = 16'(PWM_BASE_CYC + PWM_STEP_CYC * pwm_period_field);
         chk("period", e, 16'(n));
      end
      $display("period test done");
      pwm_period_field = 8'h00;
      speed_source_select = 1'b1;
      serial_speed_reference = 10'($urandom);
      speed_unit = 4'($urandom_range(15, 1));
      speed_input_pin = 10'h3ff;
      run_req = 1'b1;
      // leaving low power runs the full initialization first
      wait_st(3'h3, 600);
      wait_st(3'h4, 100);
      speed_input_pin = 10'($urandom_range(900, 1));
      repeat (3) @(negedge clk_sys);
      e = 16'(serial_speed_reference * speed_unit);
      chk("serial ref", e, 16'(ref_freq));
      $display("serial test done");
      speed_source_select = 1'b0;
      speed_input_pin = 10'h3ff;
      duty_u = 11'($urandom_range(300));
      duty_v = 11'($urandom_range(300));
      duty_w = 11'($urandom_range(300));
      for (int m = 0; m < 4; m++) begin
         switching_mode_field = 2'(m);
         // corners: threshold in mode 10, hysteresis band in mode 11
         modulation_index = (m == 2) ? 7'h32 : (m == 3) ? 7'h25
            : 7'($urandom_range(100));
         tp = (m == 0) ? 1'b1 : (m == 1) ? 1'b0
            : (modulation_index >= 7'h32) ? 1'b1
            : (m == 2 || modulation_index < 7'h19) ? 1'b0 : tp;
         periods(2);
         chk("mode", 16'(tp), 16'(two_phase_active));
      end
      e = 16'(max_reference_speed * speed_unit);
      chk("max ref", e, 16'(ref_freq));
      speed_input_pin = min_speed_voltage;
      repeat (3) @(negedge clk_sys);
      e = 16'(min_reference_speed * speed_unit);
      chk("min ref", e, 16'(ref_freq));
      speed_input_pin = 10'($urandom_range(767, 257));
      periods(2);
      chk("lin ref", lin(speed_input_pin), 16'(ref_freq));
      sync_loss_detect = 1'b1;
      repeat (2) @(negedge clk_sys);
      chk("sync loss", 16'h0001, 16'(sync_loss_flag));
      speed_input_pin = min_speed_voltage - 10'h001;
      wait_st(3'h2, 5);
      chk("sync loss", 16'h0000, 16'(sync_loss_flag));
      $display("analog test done");
      speed_input_pin = 10'h000;
      wait_st(3'h5, 5);
      // gates follow the state one cycle later
      @(negedge clk_sys);
      chk("coast gates", 16'h0000, 16'({gate_high, gate_low}));
      // exactly at the entry level still counts as low
      speed_input_pin = 10'h020;
      wait_st(3'h0, 100);
      chk("fault clear", 16'h0001, 16'(fault_clear));
      chk("low power", 16'h0001, 16'(low_power_mode));
      // exactly at the release level must not wake
      speed_input_pin = 10'h040;
      repeat (20) @(negedge clk_sys);
      chk("stay low", 16'h0000, 16'(motor_state));
      speed_input_pin = 10'h041;
      wait_st(3'h1, 5);
      chk("init gates", 16'h0000, 16'({gate_high, gate_low}));
      $display("low power test done");
      test_done();
   end
endmodule

// [rtl/dead_time_gate.sv]
/*
 * one phase leg: turns the high and low gate demands into gate drives
 * with a programmable gap where both transistors are off.
 * assumes the demands are never both high and dead_cycles is at least 1.
 */
`timescale 1ns/10ps
module dead_time_gate
   import pwm_ctl_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [DEAD_W-1:0] dead_cycles,
   input wire logic want_high,
   input wire logic want_low,
   output logic gate_high,
   output logic gate_low
);

   logic [DEAD_W-1:0] gap_q;
   logic [DEAD_W-1:0] off_cnt_q;

   // ****************************************************************
   // gate sequencing
   // ****************************************************************
   // off before partner on
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         gate_high <= 1'b0;
         gate_low <= 1'b0;
         gap_q <= '0;
      end else if (gate_high && !want_high) begin
         gate_high <= 1'b0;
         gap_q <= dead_cycles - 7'h01;
      end else if (gate_low && !want_low) begin
         gate_low <= 1'b0;
         gap_q <= dead_cycles - 7'h01;
      end else if (gap_q != '0) begin
         gap_q <= gap_q - 7'h01;
      end else if (want_high && !gate_low) begin
         gate_high <= 1'b1;
      end else if (want_low && !gate_high) begin
         gate_low <= 1'b1;
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   // helper: cycles with both transistors off, saturating
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         off_cnt_q <= '0;
      end else if (gate_high || gate_low) begin
         off_cnt_q <= '0;
      end else if (off_cnt_q != '1) begin
         off_cnt_q <= off_cnt_q + 7'h01;
      end
   end

   chk_no_overlap: assert property (@(posedge clk_sys) disable iff (reset)
      !(gate_high && gate_low))
      else $error("both gates of a leg on");

   chk_dead_gap: assert property (@(posedge clk_sys) disable iff (reset)
      ($rose(gate_low) || $rose(gate_high)) |->
         off_cnt_q >= $past(dead_cycles))
      else $error("dead time shorter than programmed");

endmodule

// [rtl/motor_speed_pwm_control.sv]
/*
 * speed reference, operating state sequencing and pwm timing of a
 * sensorless three phase driver.
 * assumes the speed input is an adc code on clk_sys, the configuration
 * fields are stable register outputs, and duties come from the loop.
 */
`timescale 1ns/10ps
module motor_speed_pwm_control
   import pwm_ctl_pkg::*;
#(
   parameter int SU_W = 4,
   parameter logic [9:0] LOW_POWER_RELEASE_LEVEL = RELEASE_LEVEL_DEF,
   parameter int PRECHARGE_STEP_CYC = PRECHARGE_STEP_DEF,
   parameter int LOW_POWER_DWELL_CYC = LOW_POWER_DWELL_DEF
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [SPEED_W-1:0] speed_input_pin,
   input wire logic sync_loss_detect,
   input wire logic run_bit,
   input wire logic brake_bit,
   input wire logic speed_source_select,
   input wire logic [SPEED_W-1:0] serial_speed_reference,
   input wire logic [SPEED_W-1:0] max_speed_voltage,
   input wire logic [SPEED_W-1:0] min_speed_voltage,
   input wire logic [SPEED_W-1:0] excitation_start_voltage,
   input wire logic [SPEED_W-1:0] low_power_entry_voltage,
   input wire logic [SPEED_W-1:0] max_reference_speed,
   input wire logic [SPEED_W-1:0] min_reference_speed,
   input wire logic [SU_W-1:0] speed_unit,
   input wire logic [7:0] pwm_period_field,
   input wire logic [5:0] dead_time_field,
   input wire logic [1:0] switching_mode_field,
   input wire logic [2:0] precharge_time_field,
   input wire logic [6:0] modulation_index,
   input wire logic [PWM_CNT_W-1:0] duty_u,
   input wire logic [PWM_CNT_W-1:0] duty_v,
   input wire logic [PWM_CNT_W-1:0] duty_w,
   output logic [2:0] gate_high,
   output logic [2:0] gate_low,
   output logic [SPEED_W+SU_W-1:0] ref_freq,
   output logic sync_loss_flag,
   output logic fault_clear,
   output logic low_power_mode,
   output logic two_phase_active,
   output logic pwm_period_start,
   output logic [2:0] motor_state
);

   localparam int FREQ_W = SPEED_W + SU_W;
   localparam int NUM_W = FREQ_W + SPEED_W;

   motor_state_e state_q, state_d;
   logic analog_sel, vsp_zero, enable_run, below_entry, dwell_done;
   logic [SPEED_W-1:0] entry_level;
   logic [TMR_W-1:0] tmr_q, dwell_q;
   logic [FREQ_W-1:0] f_rl, f_rh, f_span, serial_freq;
   logic [NUM_W-1:0] div_quo_q;
   logic [SPEED_W-1:0] div_rem_q, div_den_q;
   logic [SPEED_W:0] div_shift;
   logic [4:0] div_cnt_q;
   logic div_done_q, in_range;
   logic [PWM_CNT_W-1:0] period_cyc, pwm_cnt_q, duty_min;
   logic [PWM_CNT_W-1:0] duty_raw [3];
   logic [11:0] dead_ns_cyc;
   logic [DEAD_W-1:0] dead_cyc;
   logic two_phase_q, low_force, run_drive;
   logic [2:0] want_high, want_low;

   function automatic logic [PWM_CNT_W-1:0] min3(
      input logic [PWM_CNT_W-1:0] a,
      input logic [PWM_CNT_W-1:0] b,
      input logic [PWM_CNT_W-1:0] c);
      logic [PWM_CNT_W-1:0] m;
      m = (a < b) ? a : b;
      return (c < m) ? c : m;
   endfunction

   // ****************************************************************
   // speed source and thresholds
   // ****************************************************************
   // analog path only when selected
   assign analog_sel = !speed_source_select;
   assign vsp_zero = analog_sel && (speed_input_pin == '0);
   // motor may only run with brake 0 and run 1
   assign enable_run = run_bit && !brake_bit;
   // entry level capped at release level
   assign entry_level = (low_power_entry_voltage > LOW_POWER_RELEASE_LEVEL)
      ? LOW_POWER_RELEASE_LEVEL : low_power_entry_voltage;
   assign below_entry = analog_sel && (speed_input_pin <= entry_level);
   assign dwell_done = dwell_q >= TMR_W'(LOW_POWER_DWELL_CYC - 1);

   // dwell below entry level before low power
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         dwell_q <= '0;
      end else if (!below_entry || state_q == ST_LOW_POWER ||
                   state_q == ST_INIT) begin
         dwell_q <= '0;
      end else if (!dwell_done) begin
         dwell_q <= dwell_q + 24'h00_0001;
      end
   end

   // ****************************************************************
   // operating state
   // ****************************************************************
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         // hold low power until input above release level
         ST_LOW_POWER: begin
            if (!analog_sel || speed_input_pin > LOW_POWER_RELEASE_LEVEL) begin
               state_d = ST_INIT;
            end
         end
         ST_INIT: begin
            if (tmr_q == '0) begin
               state_d = ST_BRAKE;
            end
         end
         // brake until above excitation start voltage
         ST_BRAKE: begin
            if (vsp_zero) begin
               state_d = ST_COAST;
            end else if (dwell_done) begin
               state_d = ST_LOW_POWER;
            end else if (enable_run && (!analog_sel ||
                         speed_input_pin > excitation_start_voltage)) begin
               state_d = (precharge_time_field == 3'h0) ? ST_RUN
                  : ST_PRECHARGE;
            end
         end
         ST_PRECHARGE: begin
            if (vsp_zero) begin
               state_d = ST_COAST;
            end else if (!enable_run) begin
               state_d = ST_BRAKE;
            end else if (tmr_q == '0) begin
               state_d = ST_RUN;
            end
         end
         // run until below minimum speed voltage
         ST_RUN: begin
            if (vsp_zero) begin
               state_d = ST_COAST;
            end else if (dwell_done) begin
               state_d = ST_LOW_POWER;
            end else if (!enable_run ||
                         (analog_sel && speed_input_pin < min_speed_voltage))
            begin
               state_d = ST_BRAKE;
            end
         end
         // coast with gates off, then low power
         ST_COAST: begin
            if (dwell_done) begin
               state_d = ST_LOW_POWER;
            end else if (!analog_sel ||
                         speed_input_pin > LOW_POWER_RELEASE_LEVEL) begin
               state_d = ST_BRAKE;
            end
         end
         default: state_d = ST_INIT;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         state_q <= ST_INIT;
      end else begin
         state_q <= state_d;
      end
   end

   // shared timer: initialization, then precharge
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         tmr_q <= TMR_W'(INIT_CYC - 1);
      end else if (state_d != state_q && state_d == ST_INIT) begin
         tmr_q <= TMR_W'(INIT_CYC - 1);
      end else if (state_d != state_q && state_d == ST_PRECHARGE) begin
         tmr_q <= TMR_W'(precharge_time_field * PRECHARGE_STEP_CYC - 1);
      end else if (tmr_q != '0) begin
         tmr_q <= tmr_q - 24'h00_0001;
      end
   end

   // ****************************************************************
   // diagnostics and low power
   // ****************************************************************
   // flag follows running state
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         sync_loss_flag <= 1'b0;
      end else if (state_d != ST_RUN || brake_bit) begin
         sync_loss_flag <= 1'b0;
      end else if (sync_loss_detect) begin
         sync_loss_flag <= 1'b1;
      end
   end

   // fault clear pulse on low power entry
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         fault_clear <= 1'b0;
         low_power_mode <= 1'b0;
      end else begin
         fault_clear <= state_d == ST_LOW_POWER && state_q != ST_LOW_POWER;
         low_power_mode <= state_d == ST_LOW_POWER;
      end
   end

   // ****************************************************************
   // reference frequency
   // ****************************************************************
   // limits in 0.1 Hz units
   assign f_rl = FREQ_W'(min_reference_speed * speed_unit);
   assign f_rh = FREQ_W'(max_reference_speed * speed_unit);
   assign serial_freq = FREQ_W'(serial_speed_reference * speed_unit);
   assign f_span = (f_rh > f_rl) ? f_rh - f_rl : '0;
   assign in_range = speed_input_pin > min_speed_voltage &&
      speed_input_pin < max_speed_voltage;
   assign div_shift = {div_rem_q, div_quo_q[NUM_W-1]};

   // serial divide of span times offset by voltage span
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         div_cnt_q <= '0;
         div_quo_q <= '0;
         div_rem_q <= '0;
         div_den_q <= '0;
         div_done_q <= 1'b0;
      end else if (div_cnt_q == '0) begin
         div_done_q <= 1'b0;
         if (state_q == ST_RUN && analog_sel && in_range &&
             pwm_period_start) begin
            div_cnt_q <= 5'(NUM_W);
            div_quo_q <= NUM_W'(f_span *
               (speed_input_pin - min_speed_voltage));
            div_rem_q <= '0;
            div_den_q <= max_speed_voltage - min_speed_voltage;
         end
      end else begin
         div_cnt_q <= div_cnt_q - 5'h01;
         div_done_q <= div_cnt_q == 5'h01;
         if (div_shift >= {1'b0, div_den_q}) begin
            div_rem_q <= SPEED_W'(div_shift - {1'b0, div_den_q});
            div_quo_q <= {div_quo_q[NUM_W-2:0], 1'b1};
         end else begin
            div_rem_q <= div_shift[SPEED_W-1:0];
            div_quo_q <= {div_quo_q[NUM_W-2:0], 1'b0};
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         ref_freq <= '0;
      end else if (state_q != ST_RUN) begin
         ref_freq <= '0;
      end else if (speed_source_select) begin
         ref_freq <= serial_freq;
      end else if (speed_input_pin >= max_speed_voltage) begin
         ref_freq <= f_rh;
      end else if (speed_input_pin <= min_speed_voltage) begin
         ref_freq <= f_rl;
      end else if (div_done_q) begin
         ref_freq <= f_rl + div_quo_q[FREQ_W-1:0];
      end
   end

   // ****************************************************************
   // pwm carrier and switching mode
   // ****************************************************************
   // period from field
   assign period_cyc = PWM_CNT_W'(PWM_BASE_CYC +
      pwm_period_field * PWM_STEP_CYC);
   assign pwm_period_start = pwm_cnt_q == '0;

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         pwm_cnt_q <= '0;
      end else if (pwm_cnt_q >= period_cyc - 11'h001) begin
         pwm_cnt_q <= '0;
      end else begin
         pwm_cnt_q <= pwm_cnt_q + 11'h001;
      end
   end

   // mode changes only at period start to keep edges whole
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         two_phase_q <= 1'b0;
      end else if (pwm_period_start) begin
         unique case (switching_mode_field)
            SW_TWO_PHASE: two_phase_q <= 1'b1;
            SW_THREE_PHASE: two_phase_q <= 1'b0;
            SW_AUTO_NARROW: two_phase_q <= modulation_index >= MOD_TWO_UP_PCT;
            SW_AUTO_WIDE: begin
               if (modulation_index >= MOD_TWO_UP_PCT) begin
                  two_phase_q <= 1'b1;
               end else if (modulation_index < MOD_THREE_WIDE_PCT) begin
                  two_phase_q <= 1'b0;
               end
            end
         endcase
      end
   end

   assign two_phase_active = two_phase_q;
   assign motor_state = state_q;

   // ****************************************************************
   // gate demands and dead time
   // ****************************************************************
   // rounded up to clock, floor of 100 ns
   assign dead_ns_cyc = 12'((dead_time_field * DEAD_STEP_NS +
      CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   assign dead_cyc = (dead_ns_cyc < 12'(DEAD_MIN_CYC)) ? DEAD_W'(DEAD_MIN_CYC)
      : dead_ns_cyc[DEAD_W-1:0];

   assign duty_raw[0] = duty_u;
   assign duty_raw[1] = duty_v;
   assign duty_raw[2] = duty_w;
   assign duty_min = min3(duty_u, duty_v, duty_w);
   // only run, precharge, and brake with run_bit set drive gates
   assign run_drive = state_q == ST_RUN;
   assign low_force = state_q == ST_PRECHARGE ||
      (state_q == ST_BRAKE && run_bit);

   for (genvar i = 0; i < 3; i++) begin : g_leg
      always_comb begin
         want_high[i] = run_drive && (pwm_cnt_q <
            (two_phase_q ? duty_raw[i] - duty_min : duty_raw[i]));
         want_low[i] = low_force || (run_drive && !want_high[i]);
      end

      dead_time_gate u_leg (
         .clk_sys(clk_sys),
         .reset(reset),
         .dead_cycles(dead_cyc),
         .want_high(want_high[i]),
         .want_low(want_low[i]),
         .gate_high(gate_high[i]),
         .gate_low(gate_low[i])
      );
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);

   chk_los_idle: assert property (state_q != ST_RUN |-> !sync_loss_flag)
      else $error("sync loss flag set outside run");
   chk_serial_ref: assert property (state_q == ST_RUN &&
      speed_source_select |=> ref_freq == $past(serial_freq))
      else $error("serial reference not used");
   chk_zero_coast: assert property (vsp_zero && (state_q == ST_RUN ||
      state_q == ST_BRAKE || state_q == ST_PRECHARGE) |=> state_q == ST_COAST
      ##1 gate_high == 3'h0 && gate_low == 3'h0)
      else $error("zero input did not coast");
   chk_lp_hold: assert property (state_q == ST_LOW_POWER && analog_sel &&
      speed_input_pin <= LOW_POWER_RELEASE_LEVEL |=> state_q == ST_LOW_POWER)
      else $error("left low power too early");
   chk_init_off: assert property (state_q == ST_INIT |->
      gate_high == 3'h0 && gate_low == 3'h0)
      else $error("gates on during init");
   chk_brake_hold: assert property (state_q == ST_BRAKE && analog_sel &&
      speed_input_pin <= excitation_start_voltage |=> state_q != ST_RUN &&
      state_q != ST_PRECHARGE)
      else $error("started below excitation voltage");
   chk_clamp_max: assert property (state_q == ST_RUN && analog_sel &&
      speed_input_pin >= max_speed_voltage |=> ref_freq == $past(f_rh))
      else $error("reference not clamped");
   chk_lp_clear: assert property ($rose(state_q == ST_LOW_POWER) |->
      fault_clear && !sync_loss_flag)
      else $error("faults not cleared in low power");
   chk_period_wrap: assert property (pwm_cnt_q == period_cyc - 11'h001 &&
      $stable(pwm_period_field) |=> pwm_cnt_q == '0)
      else $error("pwm period length wrong");
   chk_mode_wide: assert property (pwm_period_start &&
      switching_mode_field == SW_AUTO_WIDE && two_phase_q &&
      modulation_index >= MOD_THREE_WIDE_PCT |=> two_phase_q)
      else $error("left two phase too early");

   cov_run: cover property ($rose(state_q == ST_RUN));
   cov_low_power: cover property ($rose(state_q == ST_LOW_POWER));
   cov_precharge: cover property (state_q == ST_PRECHARGE ##1
      state_q == ST_RUN);
   cov_two_phase: cover property ($rose(two_phase_q));

endmodule

// [rtl/pwm_ctl_pkg.sv]
/*
 * constants, codes and state type shared by the speed reference and
 * pwm timing logic of the motor driver.
 * assumes a 10 MHz system clock; all times below are converted with it.
 */
package pwm_ctl_pkg;

   // ****************************************************************
   // clock and timing
   // ****************************************************************
   localparam int CLK_PERIOD_NS = 100;
   localparam int PWM_BASE_NS = 30500;
   localparam int PWM_STEP_NS = 400;
   localparam int PWM_BASE_CYC = PWM_BASE_NS / CLK_PERIOD_NS;
   localparam int PWM_STEP_CYC = PWM_STEP_NS / CLK_PERIOD_NS;
   localparam int DEAD_STEP_NS = 50;
   localparam int DEAD_MIN_NS = 100;
   localparam int DEAD_MIN_CYC =
      (DEAD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int INIT_TIME_NS = 50000;
   localparam int INIT_CYC = INIT_TIME_NS / CLK_PERIOD_NS;
   localparam int PRECHARGE_STEP_US = 14000;
   localparam int PRECHARGE_STEP_DEF =
      PRECHARGE_STEP_US * 1000 / CLK_PERIOD_NS;
   localparam int LOW_POWER_DWELL_US = 100000;
   localparam int LOW_POWER_DWELL_DEF =
      LOW_POWER_DWELL_US * 1000 / CLK_PERIOD_NS;

   // ****************************************************************
   // widths, thresholds and codes
   // ****************************************************************
   localparam int SPEED_W = 10;
   localparam int PWM_CNT_W = 11;
   localparam int DEAD_W = 7;
   localparam int TMR_W = 24;
   localparam logic [6:0] MOD_TWO_UP_PCT = 7'h32;
   localparam logic [6:0] MOD_THREE_WIDE_PCT = 7'h19;
   localparam logic [1:0] SW_TWO_PHASE = 2'h0;
   localparam logic [1:0] SW_THREE_PHASE = 2'h1;
   localparam logic [1:0] SW_AUTO_NARROW = 2'h2;
   localparam logic [1:0] SW_AUTO_WIDE = 2'h3;
   localparam logic [9:0] RELEASE_LEVEL_DEF = 10'h040;

   typedef enum logic [2:0] {
      ST_LOW_POWER = 3'b000,
      ST_INIT = 3'b001,
      ST_BRAKE = 3'b010,
      ST_PRECHARGE = 3'b011,
      ST_RUN = 3'b100,
      ST_COAST = 3'b101
   } motor_state_e;

endpackage
